// ### core/qb_port_pkg.sv
package qb_port_pkg;
  // Port geometry
  localparam int PORT_WIDTH = 8;
  // Latch reset value: quasi-bidirectional pins come up as inputs
  localparam logic [7:0] LATCH_RESET = 8'hff;
  // Strong pull-up boost length
  localparam int BOOST_CYCLES = 2;
  localparam int BOOST_CNT_W = 2;
  // Bit position of the weak pull-up disable in the auxiliary control
  localparam int WEAK_PULLUP_DISABLE_BIT = 7;

  // Per-pin driver controls as one bundle
  typedef struct packed {
    logic [7:0] pull_down;
    logic [7:0] weak_up;
    logic [7:0] medium_up;
    logic [7:0] strong_up;
  } pin_drive_s;
endpackage : qb_port_pkg

// ### core/quasi_bidir_port_driver.sv
// Behaviour
// - Weak pull-up stays on whenever the pin latch holds one.
// - Medium pull-up on only while latch is one and pin reads one.
// - External low on a latched-one pin drops medium, leaves weak on.
// - Latch zero-to-one turns strong pull-up on for two clocks, fewer if the latch returns to zero.
// - Latch zero drives the pin low through the strong pull-down.
// - Weak pull-up disable bit turns off weak pull-up on latched-zero pins.
// - Inputs need a one in the latch; outside driver overcomes pull-ups.
`timescale 1ns/1ns
module quasi_bidir_port_driver
  import qb_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Latch write from the core
  input wire logic latch_we,
  input wire logic [WIDTH-1:0] latch_wdata,
  // Auxiliary control register bit 7
  input wire logic weak_pullup_disable,
  // Pad level
  input wire logic [WIDTH-1:0] pin_in,
  // Driver controls
  output logic [WIDTH-1:0] pull_down_en,
  output logic [WIDTH-1:0] weak_up_en,
  output logic [WIDTH-1:0] medium_up_en,
  output logic [WIDTH-1:0] strong_up_en,
  // Read-back
  output logic [WIDTH-1:0] latch_q,
  output logic [WIDTH-1:0] pin_read
);

  logic [WIDTH-1:0] latch_r, latch_nxt;
  logic [WIDTH-1:0] pin_s1_r, pin_s2_r;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] boost_nxt;
  logic [WIDTH-1:0] pd_nxt, weak_nxt, med_nxt;
  logic [BOOST_CNT_W-1:0] boost_cnt_r [WIDTH];
  logic [BOOST_CNT_W-1:0] boost_cnt_nxt [WIDTH];

  // New latch value and zero-to-one detection
  assign latch_nxt = latch_we ? latch_wdata : latch_r;
  assign rise = latch_nxt & ~latch_r;

  // Drive decode, one clock ahead of the registered outputs.
  // Medium follows the synchronized pin, so an outside low drops it.
  assign pd_nxt = ~latch_nxt;
  assign weak_nxt = latch_nxt
                  | (weak_pullup_disable ? '0 : ~latch_nxt);
  assign med_nxt = latch_nxt & pin_s2_r;

  // Boost counters load on a rising latch and count down to zero
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (rise[i]) begin
        boost_cnt_nxt[i] = BOOST_CNT_W'(BOOST_CYCLES);
      end else if (boost_cnt_r[i] != '0 && latch_nxt[i]) begin
        boost_cnt_nxt[i] = boost_cnt_r[i] - 1'b1;
      end else begin
        boost_cnt_nxt[i] = '0; // Latch back to zero aborts the boost
      end
      boost_nxt[i] = boost_cnt_nxt[i] != '0;
    end
  end

  // Latch and counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= LATCH_RESET[WIDTH-1:0];
      for (int i = 0; i < WIDTH; i++) begin
        boost_cnt_r[i] <= '0;
      end
    end else begin
      latch_r <= latch_nxt;
      boost_cnt_r <= boost_cnt_nxt;
    end
  end

  // Pin synchroniser; second stage alone feeds the logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Registered driver outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pull_down_en <= '0;
      weak_up_en <= '1;
      medium_up_en <= '0;
      strong_up_en <= '0;
      latch_q <= LATCH_RESET[WIDTH-1:0];
      pin_read <= '0;
    end else begin
      pull_down_en <= pd_nxt;
      weak_up_en <= weak_nxt;
      medium_up_en <= med_nxt;
      strong_up_en <= boost_nxt;
      latch_q <= latch_nxt;
      pin_read <= pin_s2_r;
    end
  end

  // Strong pull-up lasts two cycles after a rise, cut short if the latch returns to zero
  sequence s_rise;
    latch_we && !latch_q[0] && latch_wdata[0];
  endsequence
  // A fresh rise in the third cycle reloads the count, so it may stay on
  sequence s_boost_end;
    !strong_up_en[0] || (latch_q[0] && !$past(latch_q[0]));
  endsequence
  property p_boost_two;
    @(posedge clk) disable iff (!rst_b)
      s_rise ##1 latch_q[0] |-> strong_up_en[0] ##1
        (strong_up_en[0] || !latch_q[0]) ##1 s_boost_end;
  endproperty
  a_boost_two: assert property (p_boost_two)
    else $error("strong pull-up length wrong");

  property p_pull_down;
    @(posedge clk) disable iff (!rst_b)
      pull_down_en == ~latch_q;
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down does not follow latch");

  property p_weak;
    @(posedge clk) disable iff (!rst_b)
      (latch_q & ~weak_up_en) == '0;
  endproperty
  a_weak: assert property (p_weak)
    else $error("weak pull-up off on a latched one");

  property p_weak_dis;
    @(posedge clk) disable iff (!rst_b)
      $past(weak_pullup_disable) |-> (~latch_q & weak_up_en) == '0;
  endproperty
  a_weak_dis: assert property (p_weak_dis)
    else $error("weak pull-up on despite disable");

  property p_medium;
    @(posedge clk) disable iff (!rst_b)
      (medium_up_en & ~latch_q) == '0;
  endproperty
  a_medium: assert property (p_medium)
    else $error("medium pull-up on with latch zero");

  property p_medium_drop;
    @(posedge clk) disable iff (!rst_b)
      latch_q[0] && !pin_read[0] |-> !medium_up_en[0];
  endproperty
  a_medium_drop: assert property (p_medium_drop)
    else $error("medium pull-up held against external low");

  // Two synchroniser flops and the read register make three clocks of lag
  sequence s_three;
    1'b1 ##3 1'b1;
  endsequence
  property p_read;
    @(posedge clk) disable iff (!rst_b)
      s_three |-> pin_read == $past(pin_in, 3);
  endproperty
  a_read: assert property (p_read)
    else $error("read value not the pin level");

  property p_input_ok;
    @(posedge clk) disable iff (!rst_b)
      latch_q[0] |-> !pull_down_en[0];
  endproperty
  a_input_ok: assert property (p_input_ok)
    else $error("pull-down on for an input pin");

  property p_latch_load;
    @(posedge clk) disable iff (!rst_b)
      latch_we |=> latch_q == $past(latch_wdata);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("latch write not taken");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_b)
      !latch_we |=> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without a write");

  property p_weak_on;
    @(posedge clk) disable iff (!rst_b)
      !$past(weak_pullup_disable) |-> weak_up_en == '1;
  endproperty
  a_weak_on: assert property (p_weak_on)
    else $error("weak pull-up off while not disabled");

  property p_medium_eq;
    @(posedge clk) disable iff (!rst_b)
      medium_up_en == (latch_q & pin_read);
  endproperty
  a_medium_eq: assert property (p_medium_eq)
    else $error("medium pull-up not latch and pin level");

  property p_strong_latch;
    @(posedge clk) disable iff (!rst_b)
      (strong_up_en & ~latch_q) == '0;
  endproperty
  a_strong_latch: assert property (p_strong_latch)
    else $error("strong pull-up on a latched zero");

  property p_strong_cause;
    @(posedge clk) disable iff (!rst_b)
      $rose(strong_up_en[0]) |-> $rose(latch_q[0]);
  endproperty
  a_strong_cause: assert property (p_strong_cause)
    else $error("strong pull-up without a latch rise");

  property p_strong_three;
    @(posedge clk) disable iff (!rst_b)
      (strong_up_en & $past(strong_up_en) & $past(strong_up_en, 2)) == '0;
  endproperty
  a_strong_three: assert property (p_strong_three)
    else $error("strong pull-up on for three cycles");

endmodule : quasi_bidir_port_driver

// ### test/pad_model.sv
`timescale 1ns/1ns
module pad_model (
  // Clock and port drivers
  input wire logic clk,
  input wire logic [7:0] pull_down_en,
  input wire logic [7:0] up_en,
  // Outside device pulling pins low
  input wire logic [7:0] ext_low,
  // Resolved pad level
  output logic [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;
  // Any low driver wins; a floating pin toggles so it never reads as kept
  assign pin_in = ~(pull_down_en | ext_low) & (up_en | ~last_r);
  // Remember the last level for the floating case
  always @(posedge clk) begin
    last_r <= pin_in;
  end
endmodule : pad_model

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import qb_port_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic latch_we = 1'b0;
  logic weak_pullup_disable = 1'b0;
  logic [7:0] latch_wdata = 8'h00;
  logic [7:0] ext_low = 8'h00;
  logic [7:0] pin_in, pull_down_en, weak_up_en, medium_up_en, strong_up_en;
  logic [7:0] latch_q, pin_read, lat, rise;
  logic [31:0] lfsr = 32'he39c;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  quasi_bidir_port_driver i_dut (.clk, .rst_b, .latch_we, .latch_wdata,
    .weak_pullup_disable, .pin_in, .pull_down_en, .weak_up_en,
    .medium_up_en, .strong_up_en, .latch_q, .pin_read);
  pad_model i_pad (.clk, .pull_down_en, .ext_low, .pin_in,
    .up_en(weak_up_en | medium_up_en | strong_up_en));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Let the pin synchroniser settle, then check the steady drivers
  task automatic settle();
    repeat (5) @(negedge clk);
    chk(latch_q, lat);
    chk(pull_down_en, ~lat);
    chk(weak_up_en, lat | {8{~weak_pullup_disable}});
    chk(medium_up_en, lat & ~ext_low);
    chk(pin_read, lat & ~ext_low);
  endtask : settle
  // Hang guard, well above 60 rounds of about 9 cycles and the tail
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  // Random latch writes, disable bit and outside pull-downs
  initial begin
    lat = LATCH_RESET;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    settle();
    for (int i = 0; i < 60; i++) begin
      lfsr = step(lfsr);
      @(negedge clk);
      latch_we = 1'b1;
      latch_wdata = lfsr[7:0];
      weak_pullup_disable = lfsr[9];
      ext_low = lfsr[19:12] & lfsr[27:20];
      rise = lfsr[7:0] & ~lat;
      lat = lfsr[7:0];
      @(negedge clk);
      latch_we = 1'b0;
      chk(strong_up_en, rise);
      @(negedge clk);
      chk(strong_up_en, rise);
      @(negedge clk);
      chk(strong_up_en, 8'h00);
      settle();
    end
    // Back-to-back writes: a return to zero cuts a boost, a rise reloads
    @(negedge clk);
    latch_we = 1'b1;
    latch_wdata = 8'h00;
    @(negedge clk);
    latch_wdata = 8'hff;
    @(negedge clk);
    chk(strong_up_en, 8'hff);
    latch_wdata = 8'h0f;
    @(negedge clk);
    chk(strong_up_en, 8'h0f);
    latch_wdata = 8'hff;
    @(negedge clk);
    chk(strong_up_en, 8'hf0);
    latch_we = 1'b0;
    @(negedge clk);
    chk(strong_up_en, 8'hf0);
    @(negedge clk);
    chk(strong_up_en, 8'h00);
    lat = 8'hff;
    settle();
    // Reset in mid-run brings the port back as an input
    @(negedge clk);
    latch_we = 1'b1;
    latch_wdata = 8'h00;
    @(negedge clk);
    latch_we = 1'b0;
    rst_b = 1'b0;
    @(negedge clk);
    chk(latch_q, 8'hff);
    chk(pull_down_en, 8'h00);
    chk(weak_up_en, 8'hff);
    chk(medium_up_en, 8'h00);
    chk(strong_up_en, 8'h00);
    chk(pin_read, 8'h00);
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    settle();
    test_done();
  end
endmodule : tb_top
